// file: pwd_consts.svh
// Offsets, field positions, reset values and timing figures of the extended page 1 register pair.
// Assumes a 25 MHz management-side clock and a five-bit management register address.
//
// Contract
// R1 - Carrier-extension disable bit stops extension; resets zero.
// R2 - Sleep timer field selects one to four seconds.
// R3 - Wake-up timer selects 160, 400, 800 ms, 2 s.
// R4 - Host may flag MDC slower than 10 MHz.
// R5 - Address reversal remaps ports; valid on port zero.
// R6 - Host sets reversal via port 0, clears via 3; the code sets and clears it via port 0 only.
// R7 - Media mode status reports none, copper or serial.
// R8 - No-preamble bit lets 10BASE-T raise RX_DV.
// R9 - Downshift enable drops speed after failed negotiations.
// R10 - Downshift count field selects two to five attempts.
// R11 - Downshift status shows downshift needed or done.
// R12 - Inline power detection enable; status valid only then.
// R13 - Eight-bit counter counts copper CRC error packets.
// R14 - CRC counter saturates at FF, clears on read.
// R15 - Page one redirects addresses 16 to 30 only.
// R16 - Writing zero to register 31 restores main space.
// R17 - Sticky bits survive software reset, not hardware reset.
`ifndef PWD_CONSTS_SVH
`define PWD_CONSTS_SVH

`define PWD_ADDR_CTL3 5'h14
`define PWD_ADDR_CTL4 5'h17
`define PWD_ADDR_PAGE 5'h1F
`define PWD_ADDR_EXT_LO 5'h10
`define PWD_ADDR_EXT_HI 5'h1E
`define PWD_PAGE_EXT1 16'h0001
`define PWD_PAGE_MAIN 16'h0000

`define PWD_BIT_CEXT_DIS 15
`define PWD_BIT_SLOW_MDC 10
`define PWD_BIT_ADDR_REV 9
`define PWD_BIT_NO_PREAMBLE 5
`define PWD_BIT_DS_EN 4
`define PWD_BIT_DS_STAT 1
`define PWD_BIT_PD_EN 10
`define PWD_SLEEP_LSB 13
`define PWD_WAKE_LSB 11
`define PWD_MEDIA_LSB 6
`define PWD_DS_CNT_LSB 2
`define PWD_PORT_LSB 11
`define PWD_PD_STAT_LSB 8

`define PWD_SLEEP_RST 2'h1
`define PWD_WAKE_RST 2'h0
`define PWD_DS_CNT_RST 2'h1
`define PWD_DS_MIN_TRIES 3'h2
`define PWD_CRC_MAX 8'hFF

`define PWD_CLK_KHZ 25000
`define PWD_SLEEP_STEP_MS 1000
`define PWD_WAKE0_MS 160
`define PWD_WAKE1_MS 400
`define PWD_WAKE2_MS 800
`define PWD_WAKE3_MS 2000

`endif

// file: pwd_pkg.sv
// Types shared by the extended register pair and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package pwd_pkg;
    typedef enum logic {PWD_ACTIVE, PWD_ASLEEP} pwd_sleep_type;
endpackage

// file: pwd_crc_counter.sv
// Saturating copper CRC error counter, cleared by a management read.
// Assumes err and clr are single-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "pwd_consts.svh"
module pwd_crc_counter
    import pwd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic err,
    input wire logic clr,
    output logic [7:0] count
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // An error landing in the clearing cycle is kept, so the count restarts at one.
    always_comb begin
        cnt_d = cnt_q;
        if (clr) begin
            cnt_d = err ? 8'h01 : 8'h00; // R14
        end else if (err && cnt_q != `PWD_CRC_MAX) begin
            cnt_d = cnt_q + 8'h01; // R13
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;

    chk_crc_saturate: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
        (cnt_q == 8'hFF && !clr) |=> cnt_q == 8'hFF)
        else $error("CRC counter left saturation without a read");
    chk_crc_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
        clr |=> cnt_q == {7'h00, $past(err)})
        else $error("CRC counter not cleared by read");
    chk_crc_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
        (err && !clr && cnt_q < 8'hFF) |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("CRC error not counted");
endmodule
`default_nettype wire

// file: pwd_regs.sv
// Extended page 1 control pair of one PHY port: sleep and wake timers, downshift, inline power, CRC errors.
// Assumes an MDIO frame decoder on clk_sys hands over one-cycle read and write strobes with a register address.
`timescale 1ns/1ps
`default_nettype none
`include "pwd_consts.svh"
module pwd_regs
    import pwd_pkg::*;
#(
    parameter int unsigned SLEEP_STEP_CYC = `PWD_SLEEP_STEP_MS * `PWD_CLK_KHZ,
    parameter int unsigned WAKE0_CYC = `PWD_WAKE0_MS * `PWD_CLK_KHZ,
    parameter int unsigned WAKE1_CYC = `PWD_WAKE1_MS * `PWD_CLK_KHZ,
    parameter int unsigned WAKE2_CYC = `PWD_WAKE2_MS * `PWD_CLK_KHZ,
    parameter int unsigned WAKE3_CYC = `PWD_WAKE3_MS * `PWD_CLK_KHZ
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sw_rst,
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    output logic mgmt_ext_hit,
    input wire logic [4:0] port_id,
    input wire logic addr_rev_shared,
    output logic [4:0] port_addr,
    input wire logic [1:0] media_mode,
    input wire logic energy_det,
    input wire logic aneg_fail_1g,
    input wire logic aneg_done,
    input wire logic crc_err,
    input wire logic [1:0] pd_status,
    output logic carrier_ext_dis,
    output logic slow_mdc,
    output logic addr_reverse_en,
    output logic no_preamble_10,
    output logic downshift,
    output logic pd_detect_en,
    output logic asleep,
    output logic wake_pulse
);
    logic energy_s1_q, energy_s2_q;
    logic [15:0] page_q, page_d;
    logic cext_q, cext_d, slow_q, slow_d, rev_q, rev_d;
    logic [1:0] sleep_q, sleep_d, wake_q, wake_d, dscnt_q, dscnt_d;
    logic nopre_q, nopre_d, dsen_q, dsen_d, pden_q, pden_d;
    logic ds_q, ds_d;
    logic [2:0] fails_q, fails_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q;
    logic ext1, wr20, wr23, rd23;
    logic [7:0] crc_count;
    logic [15:0] ctl3_val, ctl4_val;
    pwd_sleep_type st_q, st_d;
    logic [31:0] tmr_q, tmr_d, sleep_lim, wake_lim, quiet_q, quiet_d, gap_q, gap_d;
    logic wake_d_p, wake_q_p;

    // The energy detect comes from the analog front end.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            energy_s1_q <= 1'b0;
            energy_s2_q <= 1'b0;
        end else begin
            energy_s1_q <= energy_det;
            energy_s2_q <= energy_s1_q;
        end
    end
    assign ext1 = (page_q == `PWD_PAGE_EXT1);
    assign mgmt_ext_hit = ext1 && mgmt_addr >= `PWD_ADDR_EXT_LO && mgmt_addr <= `PWD_ADDR_EXT_HI; // R15
    assign wr20 = mgmt_wr && ext1 && mgmt_addr == `PWD_ADDR_CTL3;
    assign wr23 = mgmt_wr && ext1 && mgmt_addr == `PWD_ADDR_CTL4;
    assign rd23 = mgmt_rd && ext1 && mgmt_addr == `PWD_ADDR_CTL4;
    // Sticky fields take only the hardware reset; the rest also fall back on a software reset.
    always_comb begin
        page_d = page_q;
        cext_d = cext_q;
        slow_d = slow_q;
        rev_d = rev_q;
        sleep_d = sleep_q;
        wake_d = wake_q;
        nopre_d = nopre_q;
        dsen_d = dsen_q;
        dscnt_d = dscnt_q;
        pden_d = pden_q;
        if (mgmt_wr && mgmt_addr == `PWD_ADDR_PAGE) begin
            page_d = mgmt_wdata; // R16
        end
        if (wr20) begin
            cext_d = mgmt_wdata[`PWD_BIT_CEXT_DIS]; // R1
            sleep_d = mgmt_wdata[`PWD_SLEEP_LSB +: 2]; // R2
            wake_d = mgmt_wdata[`PWD_WAKE_LSB +: 2]; // R3
            slow_d = mgmt_wdata[`PWD_BIT_SLOW_MDC];
            nopre_d = mgmt_wdata[`PWD_BIT_NO_PREAMBLE]; // R8
            dsen_d = mgmt_wdata[`PWD_BIT_DS_EN]; // R9
            dscnt_d = mgmt_wdata[`PWD_DS_CNT_LSB +: 2]; // R10
            if (port_id == 5'h00) begin
                rev_d = mgmt_wdata[`PWD_BIT_ADDR_REV]; // R5
            end
        end
        if (wr23) begin
            pden_d = mgmt_wdata[`PWD_BIT_PD_EN]; // R12
        end
        if (sw_rst) begin
            page_d = `PWD_PAGE_MAIN;
            cext_d = 1'b0; // R17
            slow_d = 1'b0;
            rev_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= `PWD_PAGE_MAIN;
            cext_q <= 1'b0;
            slow_q <= 1'b0;
            rev_q <= 1'b0;
            sleep_q <= `PWD_SLEEP_RST;
            wake_q <= `PWD_WAKE_RST;
            nopre_q <= 1'b0;
            dsen_q <= 1'b0;
            dscnt_q <= `PWD_DS_CNT_RST;
            pden_q <= 1'b0;
        end else begin
            page_q <= page_d;
            cext_q <= cext_d;
            slow_q <= slow_d;
            rev_q <= rev_d;
            sleep_q <= sleep_d;
            wake_q <= wake_d;
            nopre_q <= nopre_d;
            dsen_q <= dsen_d;
            dscnt_q <= dscnt_d;
            pden_q <= pden_d;
        end
    end

    // Failures are counted only while enabled; a good negotiation restarts the tally.
    always_comb begin
        fails_d = fails_q;
        ds_d = ds_q;
        if (!dsen_q || sw_rst) begin
            fails_d = 3'h0;
            ds_d = 1'b0;
        end else if (aneg_fail_1g && !ds_q) begin
            fails_d = fails_q + 3'h1; // R9
            if (fails_q + 3'h1 >= {1'b0, dscnt_q} + `PWD_DS_MIN_TRIES) begin
                ds_d = 1'b1; // R10
            end
        end else if (aneg_done) begin
            fails_d = 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fails_q <= 3'h0;
            ds_q <= 1'b0;
        end else begin
            fails_q <= fails_d;
            ds_q <= ds_d;
        end
    end

    assign sleep_lim = SLEEP_STEP_CYC * ({30'h0, sleep_q} + 32'h1); // R2
    assign wake_lim = wake_q[1] ? (wake_q[0] ? WAKE3_CYC : WAKE2_CYC) : (wake_q[0] ? WAKE1_CYC : WAKE0_CYC); // R3

    // A quiet line for the sleep delay puts the port to sleep; it then pulses at the wake interval.
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q + 32'h1;
        wake_d_p = 1'b0;
        quiet_d = energy_s2_q ? 32'h0 : quiet_q + 32'h1;
        gap_d = (wake_q_p || st_q != PWD_ASLEEP) ? 32'h0 : gap_q + 32'h1;
        unique case (st_q)
            PWD_ACTIVE: begin
                if (energy_s2_q) begin
                    tmr_d = 32'h0;
                end else if (tmr_q + 32'h1 >= sleep_lim) begin
                    st_d = PWD_ASLEEP;
                    tmr_d = 32'h0;
                end
            end
            PWD_ASLEEP: begin
                if (energy_s2_q) begin
                    st_d = PWD_ACTIVE;
                    tmr_d = 32'h0;
                end else if (tmr_q + 32'h1 >= wake_lim) begin
                    wake_d_p = 1'b1;
                    tmr_d = 32'h0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PWD_ACTIVE;
            tmr_q <= 32'h0;
            wake_q_p <= 1'b0;
            quiet_q <= 32'h0;
            gap_q <= 32'h0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            wake_q_p <= wake_d_p;
            quiet_q <= quiet_d;
            gap_q <= gap_d;
        end
    end

    pwd_crc_counter u_crc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .err(crc_err),
        .clr(rd23),
        .count(crc_count)
    );
    assign ctl3_val = {cext_q, sleep_q, wake_q, slow_q, rev_q, 1'b0, media_mode, nopre_q, dsen_q, dscnt_q,
        ds_q, 1'b0}; // R7
    assign ctl4_val = {port_id, pden_q, (pden_q ? pd_status : 2'h0), crc_count}; // R12

    // Addresses outside page 1 read as zero here, except register 31, which returns the page; the main space answers them elsewhere.
    always_comb begin
        rdata_d = rdata_q;
        if (mgmt_rd) begin
            rdata_d = 16'h0000;
            if (ext1 && mgmt_addr == `PWD_ADDR_CTL3) begin
                rdata_d = ctl3_val; // R11
            end else if (rd23) begin
                rdata_d = ctl4_val; // R13
            end else if (mgmt_addr == `PWD_ADDR_PAGE) begin
                rdata_d = page_q;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= mgmt_rd;
        end
    end
    assign mgmt_rdata = rdata_q;
    assign mgmt_rvalid = rvalid_q;
    assign port_addr = addr_rev_shared ? {3'h0, 2'h3 - port_id[1:0]} : port_id; // R5
    assign carrier_ext_dis = cext_q;
    assign slow_mdc = slow_q; // R4
    assign addr_reverse_en = rev_q; // R6
    assign no_preamble_10 = nopre_q;
    assign downshift = ds_q;
    assign pd_detect_en = pden_q;
    assign asleep = (st_q == PWD_ASLEEP);
    assign wake_pulse = wake_q_p;
    sequence seq_wr20;
        wr20 && !sw_rst;
    endsequence
    sequence seq_rd20;
        mgmt_rd && ext1 && mgmt_addr == `PWD_ADDR_CTL3;
    endsequence
    chk_cext_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
        seq_wr20 |=> carrier_ext_dis == $past(mgmt_wdata[15]))
        else $error("Carrier extension disable did not follow write");
    chk_sleep_entry: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
        $rose(asleep) |-> quiet_q >= sleep_lim)
        else $error("Sleep entered before the delay ran out");
    chk_wake_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
        wake_pulse |-> asleep && gap_q + 32'h1 >= wake_lim)
        else $error("Wake pulse outside the wake interval");
    chk_rev_port0: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
        (seq_wr20 and port_id != 5'h00) |=> addr_reverse_en == $past(addr_reverse_en))
        else $error("Address reversal changed on a port other than zero");
    chk_media_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
        seq_rd20 |=> mgmt_rvalid && mgmt_rdata[7:6] == $past(media_mode))
        else $error("Media mode status read wrong");
    chk_ds_cause: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
        $rose(downshift) |-> $past(dsen_q) && $past(aneg_fail_1g) && $past(fails_q) + 3'h1 >= $past(dscnt_q) + 3'h2)
        else $error("Downshift raised without enough failures");
    chk_pd_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
        (rd23 && !pden_q) |=> mgmt_rdata[9:8] == 2'h0)
        else $error("Detection status shown while detection is off");
    chk_page_miss: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
        (mgmt_rd && !ext1 && mgmt_addr == `PWD_ADDR_CTL3) |=> mgmt_rdata == 16'h0000)
        else $error("Extended register visible outside page 1");
    chk_page_main: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
        (mgmt_wr && mgmt_addr == `PWD_ADDR_PAGE && mgmt_wdata == 16'h0000) |=> !mgmt_ext_hit)
        else $error("Writing zero to the page register did not restore main space");
    chk_sticky_keep: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
        (sw_rst && !wr20) |=> sleep_q == $past(sleep_q) && dscnt_q == $past(dscnt_q))
        else $error("Sticky field lost on software reset");
endmodule
`default_nettype wire

// file: pwd_unused_placeholder_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: pwd_host_model.sv
// Station management host model that issues one-cycle register strobes.
// Assumes the bench calls its tasks from a falling edge of the shared clock.
`timescale 1ns/1ps
`default_nettype none
module pwd_host_model (
    input wire logic clk_sys,
    output logic [4:0] mgmt_addr,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid
);
    initial begin
        mgmt_addr = 5'h00;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_wdata = 16'h0000;
    end
    // Released lines show the inverse so a stale value is never taken for a fresh one.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_wr = 1'b1;
        @(negedge clk_sys);
        mgmt_wr = 1'b0;
        mgmt_addr = ~a;
        mgmt_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        @(negedge clk_sys);
        mgmt_addr = a;
        mgmt_rd = 1'b1;
        @(negedge clk_sys);
        mgmt_rd = 1'b0;
        mgmt_addr = ~a;
        ok = mgmt_rvalid;
        d = mgmt_rdata;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the extended register pair against an integer register model.
// Assumes the host model file and shortened sleep and wake counts.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic sw_rst = 1'b0;
    logic [4:0] mgmt_addr;
    logic mgmt_wr, mgmt_rd, mgmt_rvalid, mgmt_ext_hit;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    logic [4:0] port_id = 5'h00;
    logic [4:0] port_addr;
    logic addr_rev_shared = 1'b0;
    logic [1:0] media_mode = 2'h1;
    logic [1:0] pd_status = 2'h0;
    logic energy_det = 1'b1;
    logic aneg_fail_1g = 1'b0;
    logic aneg_done = 1'b0;
    logic crc_err = 1'b0;
    logic carrier_ext_dis, slow_mdc, addr_reverse_en, no_preamble_10, downshift, pd_detect_en, asleep, wake_pulse;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 32'h4170ee94;
    int pg = 0, b15 = 0, slp = 1, wak = 0, b10 = 0, b9 = 0, b5 = 0, b4 = 0, cnt = 1, ds = 0, tally = 0, pd_en = 0;
    int crc = 0, i, k, d;
    logic [15:0] rv;
    logic ok;
    always #20 clk_sys = ~clk_sys;
    pwd_host_model host (.clk_sys, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid);
    pwd_regs #(.SLEEP_STEP_CYC(20), .WAKE0_CYC(4), .WAKE1_CYC(6), .WAKE2_CYC(8), .WAKE3_CYC(10)) uut (
        .clk_sys, .rst_n, .sw_rst, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid,
        .mgmt_ext_hit, .port_id, .addr_rev_shared, .port_addr, .media_mode, .energy_det, .aneg_fail_1g,
        .aneg_done, .crc_err, .pd_status, .carrier_ext_dis, .slow_mdc, .addr_reverse_en, .no_preamble_10,
        .downshift, .pd_detect_en, .asleep, .wake_pulse);
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [15:0] e14();
        return 16'(b15 << 15 | slp << 13 | wak << 11 | b10 << 10 | b9 << 9 | media_mode << 6 | b5 << 5 | b4 << 4
            | cnt << 2 | ds << 1);
    endfunction
    task automatic mwr(input logic [4:0] a, input logic [15:0] v);
        host.wr(a, v);
        if (a == 5'h1F) pg = v;
        if (pg == 1 && a == 5'h17) pd_en = v[10];
        if (pg == 1 && a == 5'h14) begin
            b15 = v[15];
            slp = v[14:13];
            wak = v[12:11];
            b10 = v[10];
            b5 = v[5];
            b4 = v[4];
            cnt = v[3:2];
            if (b4 == 0) begin
                ds = 0;
                tally = 0;
            end
            if (port_id == 5'h00) b9 = v[9];
        end
    endtask
    task automatic mrd(input logic [4:0] a);
        logic [15:0] e;
        e = 16'h0000;
        if (a == 5'h1F) e = pg[15:0];
        if (pg == 1 && a == 5'h14) e = e14();
        if (pg == 1 && a == 5'h17) e = 16'(port_id << 11 | pd_en << 10 | (pd_en ? pd_status : 0) << 8 | crc);
        host.rd(a, rv, ok);
        chk("rvalid", 16'h0001, {15'h0, ok});
        chk("rdata", e, rv);
        if (pg == 1 && a == 5'h17) crc = 0;
    endtask
    task automatic outs();
        chk("levels", 16'(b15 << 5 | b10 << 4 | b9 << 3 | b5 << 2 | ds << 1 | pd_en),
            {10'h0, carrier_ext_dis, slow_mdc, addr_reverse_en, no_preamble_10, downshift, pd_detect_en});
    endtask
    task automatic pulse(input int kind);
        @(negedge clk_sys);
        crc_err = (kind == 1);
        aneg_fail_1g = (kind == 0);
        aneg_done = (kind == 2);
        @(negedge clk_sys);
        crc_err = 1'b0;
        aneg_fail_1g = 1'b0;
        aneg_done = 1'b0;
        if (kind == 1) crc = (crc < 255) ? crc + 1 : 255;
        else if (kind == 0 && b4 == 1) tally++;
        else if (kind == 2) tally = 0;
        if (b4 == 1 && tally >= cnt + 2) ds = 1;
    endtask
    task automatic soft_reset();
        @(negedge clk_sys);
        sw_rst = 1'b1;
        @(negedge clk_sys);
        sw_rst = 1'b0;
        pg = 0;
        b15 = 0;
        b10 = 0;
        b9 = 0;
        ds = 0;
        tally = 0;
    endtask
    task automatic hw_reset();
        @(negedge clk_sys);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        pg = 0;
        b15 = 0;
        slp = 1;
        wak = 0;
        b10 = 0;
        b9 = 0;
        b5 = 0;
        b4 = 0;
        cnt = 1;
        ds = 0;
        tally = 0;
        pd_en = 0;
        crc = 0;
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        $display("[ERR] watchdog expected done seen hang");
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        mrd(5'h14);
        mwr(5'h14, 16'hFFFF);
        mwr(5'h1F, 16'h0002);
        mrd(5'h14);
        mwr(5'h1F, 16'h0001);
        mrd(5'h14);
        mrd(5'h17);
        for (i = 0; i < 12; i++) begin
            port_id = 5'(i % 4);
            media_mode = 2'($random(seed));
            d = $random(seed);
            if (port_id != 5'h00) d = d & 32'hFFFFFDFF;
            mwr(5'h14, 16'(d));
            mrd(5'h14);
            outs();
            addr_rev_shared = 1'($random(seed));
            #1 chk("port_addr", 16'(addr_rev_shared ? 3 - port_id : port_id), {11'h0, port_addr});
        end
        port_id = 5'h00;
        for (k = 0; k < 4; k++) begin
            soft_reset();
            mwr(5'h1F, 16'h0001);
            mrd(5'h14);
            mwr(5'h14, 16'(32'h8610 | k << 2));
            pulse(0);
            pulse(2);
            for (i = 0; i < k + 2; i++) begin
                chk("downshift", 16'(ds), {15'h0, downshift});
                pulse(0);
            end
            repeat (2) @(negedge clk_sys);
            outs();
            mrd(5'h14);
        end
        repeat (1 + ($random(seed) & 15)) pulse(1);
        mrd(5'h17);
        mrd(5'h17);
        repeat (260) pulse(1);
        mrd(5'h17);
        mrd(5'h17);
        for (k = 0; k < 4; k++) begin
            pd_status = 2'(k);
            mwr(5'h17, 16'((k % 2) << 10));
            mrd(5'h17);
            outs();
        end
        for (k = 0; k < 4; k++) begin
            mwr(5'h14, 16'(k << 13 | k << 11));
            energy_det = 1'b0;
            i = 0;
            while (asleep !== 1'b1 && i < 200) begin
                @(negedge clk_sys);
                i++;
            end
            chk("sleep_delay", 16'h0001, 16'(i >= 20 * (k + 1) && i <= 20 * (k + 1) + 4));
            i = 0;
            while (wake_pulse !== 1'b1 && i < 50) begin
                @(negedge clk_sys);
                i++;
            end
            i = 0;
            do begin
                @(negedge clk_sys);
                i++;
            end while (wake_pulse !== 1'b1 && i < 50);
            chk("wake_gap", 16'(4 + 2 * k), 16'(i));
            energy_det = 1'b1;
            repeat (6) @(negedge clk_sys);
            chk("asleep", 16'h0000, {15'h0, asleep});
        end
        hw_reset();
        outs();
        mwr(5'h1F, 16'h0001);
        mrd(5'h14);
        mrd(5'h17);
        mwr(5'h1F, 16'h0000);
        mrd(5'h17);
        mrd(5'h1F);
        print_verdict();
    end
endmodule
`default_nettype wire
